//--- rtl/i2ccr_top.sv
// Control register file, pin hand-over and clock stretch release of port 2
`timescale 1ns/1ps
module i2ccr_top
  import i2ccr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // Bus pins, open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  output logic             sda_out,
  output logic             sda_oe_n,
  // General-purpose port drive of the same pins
  input  wire logic        gpio_scl_out,
  input  wire logic        gpio_scl_oe_n,
  input  wire logic        gpio_sda_out,
  input  wire logic        gpio_sda_oe_n,
  // Chip power state
  input  wire logic        sys_idle,
  // From the protocol engine
  input  wire logic        eng_scl_low,
  input  wire logic        eng_sda_low,
  input  wire logic        slave_active,
  input  wire logic        slave_tx_start,
  input  wire logic        slave_rx_done,
  input  wire logic [4:0]  seq_done,
  input  wire logic [15:0] status_live,
  input  wire logic [15:0] status_event,
  input  wire logic        rx_load,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        port1_rx_load,
  input  wire logic [7:0]  port1_rx_byte,
  // To the protocol engine
  output logic             module_on,
  output logic             module_run,
  output logic      [15:0] ctl_value,
  output logic      [9:0]  own_address,
  output logic      [9:0]  address_mask,
  output logic      [11:0] baud_divider,
  output logic      [7:0]  tx_byte,
  output logic             tx_write,
  output logic             scl_sync,
  output logic             sda_sync,
  output logic             scl_rise,
  output logic             scl_fall
);

  i2ccr_pin_if pins ();

  i2ccr_bus_state_t bus_state;
  logic [31:0]      module_control_register;
  logic [31:0]      status_flags;
  logic [31:0]      own_address_reg;
  logic [31:0]      address_mask_reg;
  logic [31:0]      baud_divider_reg;
  logic [31:0]      transmit_byte;
  logic [31:0]      receive_holding_register;
  logic [31:0]      port1_receive_byte;
  logic             wr_pend;
  logic [15:0]      wr_addr;
  logic [15:0]      rd_addr;
  logic             addr_take;
  logic [15:0]      wr_base;
  logic [1:0]       wr_op;
  logic [31:0]      wr_old;
  logic [31:0]      wr_impl;
  logic [31:0]      wr_new;
  logic [31:0]      next_hrdata;
  logic             wr_con;
  logic             wr_stat;
  logic             wr_add;
  logic             wr_msk;
  logic             wr_brg;
  logic             wr_trn;
  logic             rel_hw_clear;
  logic             rel_sw_zero_ok;
  logic             stretch_hold;

  // Pin synchroniser and edge finder
  i2ccr_pin_sync u_pin_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .pins     (pins.sync_side)
  );

  // Alias arithmetic for the register addressed by the pending write
  i2ccr_alias_wr u_alias_wr (
    .op        (wr_op),
    .old_value (wr_old),
    .wdata     (hwdata),
    .impl_mask (wr_impl),
    .new_value (wr_new)
  );

  // Address phase accepted by this slave
  assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);

  // Base offset and alias operation of the pending write
  assign wr_base = {wr_addr[15:4], 4'h0};
  assign wr_op   = wr_addr[3:2];

  // Old value, implemented mask and strobes of the written register
  always_comb begin
    wr_old  = ZERO_32;
    wr_impl = ZERO_32;
    wr_con  = 1'b0;
    wr_stat = 1'b0;
    wr_add  = 1'b0;
    wr_msk  = 1'b0;
    wr_brg  = 1'b0;
    wr_trn  = 1'b0;
    if (wr_pend) begin
      case (wr_base)
        OFS_P2_CON: begin
          wr_old  = module_control_register;
          wr_impl = CON_MASK;
          wr_con  = 1'b1;
        end
        OFS_P2_STAT: begin
          wr_old  = status_flags;
          wr_impl = STAT_MASK;
          wr_stat = 1'b1;
        end
        OFS_P2_ADD: begin
          wr_old  = own_address_reg;
          wr_impl = ADD_MASK;
          wr_add  = 1'b1;
        end
        OFS_P2_MSK: begin
          wr_old  = address_mask_reg;
          wr_impl = MSK_MASK;
          wr_msk  = 1'b1;
        end
        OFS_P2_BRG: begin
          wr_old  = baud_divider_reg;
          wr_impl = BRG_MASK;
          wr_brg  = 1'b1;
        end
        OFS_P2_TRN: begin
          wr_old  = transmit_byte;
          wr_impl = TRN_MASK;
          wr_trn  = 1'b1;
        end
        default: begin
          wr_old  = ZERO_32;
          wr_impl = ZERO_32;
        end
      endcase
    end
  end

  // Read mux; every register answers only at its base word
  always_comb begin
    case (rd_addr)
      OFS_P1_RCV:  next_hrdata = port1_receive_byte;
      OFS_P2_CON:  next_hrdata = module_control_register;
      OFS_P2_STAT: next_hrdata = status_flags;
      OFS_P2_ADD:  next_hrdata = own_address_reg;
      OFS_P2_MSK:  next_hrdata = address_mask_reg;
      OFS_P2_BRG:  next_hrdata = baud_divider_reg;
      OFS_P2_TRN:  next_hrdata = transmit_byte;
      OFS_P2_RCV:  next_hrdata = receive_holding_register;
      default:     next_hrdata = ZERO_32;
    endcase
  end

  // Bus slave: writes in zero waits, reads with one wait state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= ZERO_32;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 16'h0000;
      rd_addr   <= 16'h0000;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          wr_pend <= addr_take & hwrite;
          wr_addr <= haddr[15:0];
          if (addr_take && !hwrite) begin
            rd_addr   <= haddr[15:0];
            hreadyout <= 1'b0;
            bus_state <= BUS_RDATA;
          end
        end
        BUS_RDATA: begin
          wr_pend   <= 1'b0;
          hrdata    <= next_hrdata;
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
        default: begin
          wr_pend   <= 1'b0;
          hreadyout <= 1'b1;
          bus_state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Hardware clears of the clock-line release bit
  assign rel_hw_clear = slave_tx_start
                      | (slave_rx_done & module_control_register[CON_STR_EN]);

  // A written zero only sticks when stretching is enabled
  assign rel_sw_zero_ok = module_control_register[CON_STR_EN];

  // Control register with hardware-cleared bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_control_register <= CON_RESET;
    end else begin
      if (wr_con) begin
        module_control_register <= wr_new;
        if (!rel_sw_zero_ok && module_control_register[CON_CLK_REL]) begin
          module_control_register[CON_CLK_REL] <= 1'b1;
        end
      end
      if (rel_hw_clear) begin
        module_control_register[CON_CLK_REL] <= 1'b0;
      end
      if (|seq_done) begin
        module_control_register[4:0] <= (wr_con ? wr_new[4:0] : module_control_register[4:0])
                                        & ~seq_done;
      end
    end
  end

  // Status: live bits follow the engine, clearable bits are sticky
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_flags <= ZERO_32;
    end else begin
      status_flags <= ((({16'h0000, status_live} & ~STAT_RC_MASK)
                      | (status_flags & STAT_RC_MASK & (wr_stat ? wr_new : ~ZERO_32))
                      | ({16'h0000, status_event} & STAT_RC_MASK)) & STAT_MASK);
    end
  end

  // Address, mask, divider and transmit registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      own_address_reg  <= ZERO_32;
      address_mask_reg <= ZERO_32;
      baud_divider_reg <= ZERO_32;
      transmit_byte    <= ZERO_32;
      tx_write         <= 1'b0;
    end else begin
      if (wr_add) begin
        own_address_reg <= wr_new;
      end
      if (wr_msk) begin
        address_mask_reg <= wr_new;
      end
      if (wr_brg) begin
        baud_divider_reg <= wr_new;
      end
      if (wr_trn) begin
        transmit_byte <= wr_new;
      end
      tx_write <= wr_trn;
    end
  end

  // Receive registers, loaded by the engine only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_holding_register <= ZERO_32;
      port1_receive_byte       <= ZERO_32;
    end else begin
      if (rx_load) begin
        receive_holding_register <= {24'h000000, rx_byte};
      end
      if (port1_rx_load) begin
        port1_receive_byte <= {24'h000000, port1_rx_byte};
      end
    end
  end

  // Slave holds the clock low while release is zero
  assign stretch_hold = slave_active & ~module_control_register[CON_CLK_REL];

  // Pin ownership and drive: port logic when off, serial module when on
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_out  <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (!module_control_register[CON_ON]) begin
      scl_out  <= gpio_scl_out;
      scl_oe_n <= gpio_scl_oe_n;
      sda_out  <= gpio_sda_out;
      sda_oe_n <= gpio_sda_oe_n;
    end else begin
      scl_out  <= 1'b0;
      sda_out  <= 1'b0;
      if (module_run) begin
        scl_oe_n <= ~(stretch_hold | eng_scl_low);
        sda_oe_n <= ~eng_sda_low;
      end else begin
        scl_oe_n <= 1'b1;
        sda_oe_n <= 1'b1;
      end
    end
  end

  // Run state and register copies for the engine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_on    <= 1'b0;
      module_run   <= 1'b0;
      ctl_value    <= CON_RESET[15:0];
      own_address  <= 10'h000;
      address_mask <= 10'h000;
      baud_divider <= 12'h000;
      tx_byte      <= 8'h00;
    end else begin
      module_on    <= module_control_register[CON_ON];
      module_run   <= module_control_register[CON_ON]
                    & ~(module_control_register[CON_HALT_IDLE] & sys_idle);
      ctl_value    <= module_control_register[15:0];
      own_address  <= own_address_reg[9:0];
      address_mask <= address_mask_reg[9:0];
      baud_divider <= baud_divider_reg[11:0];
      tx_byte      <= transmit_byte[7:0];
    end
  end

  // Registered pin view; edges only while the module runs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync <= 1'b1;
      sda_sync <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
    end else begin
      scl_sync <= pins.scl_level;
      sda_sync <= pins.sda_level;
      scl_rise <= pins.scl_rise & module_run;
      scl_fall <= pins.scl_fall & module_run;
    end
  end

endmodule : i2ccr_top

//--- rtl/i2ccr_pkg.sv
// Constants, types and register map of the two-wire port control block
package i2ccr_pkg;

  // Register byte offsets
  localparam logic [15:0] OFS_P1_RCV  = 16'h5060;
  localparam logic [15:0] OFS_P2_CON  = 16'h5100;
  localparam logic [15:0] OFS_P2_STAT = 16'h5110;
  localparam logic [15:0] OFS_P2_ADD  = 16'h5120;
  localparam logic [15:0] OFS_P2_MSK  = 16'h5130;
  localparam logic [15:0] OFS_P2_BRG  = 16'h5140;
  localparam logic [15:0] OFS_P2_TRN  = 16'h5150;
  localparam logic [15:0] OFS_P2_RCV  = 16'h5160;

  // Alias operation, taken from address bits 3:2
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_CLR   = 2'h1;
  localparam logic [1:0] OP_SET   = 2'h2;
  localparam logic [1:0] OP_INV   = 2'h3;

  // Control register fields
  localparam int CON_ON        = 15;
  localparam int CON_HALT_IDLE = 13;
  localparam int CON_CLK_REL   = 12;
  localparam int CON_STR_EN    = 6;
  localparam logic [31:0] CON_RESET   = 32'h0000_1000;
  localparam logic [31:0] CON_MASK    = 32'h0000_bfff;
  localparam logic [31:0] CON_HC_MASK = 32'h0000_001f;

  // Status register fields: implemented and software-clearable bits
  localparam logic [31:0] STAT_MASK    = 32'h0000_c7ff;
  localparam logic [31:0] STAT_RC_MASK = 32'h0000_04d8;

  // Implemented widths of the remaining registers
  localparam logic [31:0] ADD_MASK = 32'h0000_03ff;
  localparam logic [31:0] MSK_MASK = 32'h0000_03ff;
  localparam logic [31:0] BRG_MASK = 32'h0000_0fff;
  localparam logic [31:0] TRN_MASK = 32'h0000_00ff;
  localparam logic [31:0] ZERO_32  = 32'h0000_0000;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b01,
    BUS_RDATA = 2'b10
  } i2ccr_bus_state_t;

endpackage : i2ccr_pkg

//--- rtl/i2ccr_pin_if.sv
// Synchronised pin levels and clock-line edges shared between modules
`timescale 1ns/1ps
interface i2ccr_pin_if;
  logic scl_level;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;

  modport sync_side (output scl_level, output sda_level, output scl_rise, output scl_fall);
  modport core_side (input scl_level, input sda_level, input scl_rise, input scl_fall);
endinterface : i2ccr_pin_if

//--- rtl/i2ccr_pin_sync.sv
// Two-stage synchronisers for both bus pins and clock-line edge detection
`timescale 1ns/1ps
module i2ccr_pin_sync
  import i2ccr_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Raw pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Synchronised view
  i2ccr_pin_if.sync_side pins
);
  logic [1:0] scl_pipe;
  logic [1:0] sda_pipe;
  logic       scl_last;

  // Two flip-flops per pin, then one more stage for edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_pipe <= 2'h3;
      sda_pipe <= 2'h3;
      scl_last <= 1'b1;
    end else begin
      scl_pipe <= {scl_pipe[0], scl_in};
      sda_pipe <= {sda_pipe[0], sda_in};
      scl_last <= scl_pipe[1];
    end
  end

  // Levels and single-cycle edge strobes
  assign pins.scl_level = scl_pipe[1];
  assign pins.sda_level = sda_pipe[1];
  assign pins.scl_rise  = scl_pipe[1] & ~scl_last;
  assign pins.scl_fall  = ~scl_pipe[1] & scl_last;
endmodule : i2ccr_pin_sync

//--- rtl/i2ccr_alias_wr.sv
// Computes the value a plain, clear, set or invert write leaves in a register
`timescale 1ns/1ps
module i2ccr_alias_wr
  import i2ccr_pkg::*;
(
  // Write request
  input  wire logic [1:0]  op,
  input  wire logic [31:0] old_value,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] impl_mask,
  // Result
  output logic      [31:0] new_value
);
  // Only written ones act on aliases; unimplemented bits stay zero
  always_comb begin
    case (op)
      OP_CLR:  new_value = old_value & ~wdata;
      OP_SET:  new_value = old_value | wdata;
      OP_INV:  new_value = old_value ^ wdata;
      default: new_value = wdata;
    endcase
    new_value = new_value & impl_mask;
  end
endmodule : i2ccr_alias_wr

//--- sim/i2ccr_top_monitor.sv
// Port-level assertions for the control and clock release block
`timescale 1ns/1ps
module i2ccr_top_monitor
  import i2ccr_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Bus side
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  // Pins and engine side
  input wire logic        scl_in,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        gpio_scl_oe_n,
  input wire logic        gpio_sda_oe_n,
  input wire logic        sys_idle,
  input wire logic        slave_active,
  input wire logic        slave_tx_start,
  input wire logic        slave_rx_done,
  input wire logic        eng_scl_low,
  input wire logic        module_on,
  input wire logic        module_run,
  input wire logic [15:0] ctl_value,
  input wire logic        scl_sync
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read address phase taken
  wire rd_req = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  // One wait cycle, then the answer
  sequence read_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // Stretch cleared by a received byte with stretching enabled
  sequence rx_stretch;
    slave_rx_done ##1 ctl_value[6];
  endsequence
  chk_read_wait: assert property (rd_req |=> read_wait)
    else $error("Read answer timing wrong");
  chk_pins_port: assert property ($past(rst_n) && !module_on |->
    scl_oe_n == $past(gpio_scl_oe_n) && sda_oe_n == $past(gpio_sda_oe_n))
    else $error("Pins not handed to port logic");
  // Pin drive follows the run state of the cycle before
  chk_halt_release: assert property (
    module_on && !$past(module_run) |-> scl_oe_n && sda_oe_n)
    else $error("Halted module still drives a pin");
  chk_run_idle: assert property ($past(rst_n) |->
    module_run == (ctl_value[15] && !(ctl_value[13] && $past(sys_idle))))
    else $error("Run state does not follow enable and idle");
  chk_tx_clears: assert property (slave_tx_start |-> ##2 !ctl_value[12])
    else $error("Release bit not cleared at transmit start");
  chk_rx_clears: assert property (rx_stretch |-> ##1 !ctl_value[12])
    else $error("Release bit not cleared after reception");
  chk_stretch_low: assert property (
    ctl_value[15] && $past(module_run) && $past(slave_active) && !ctl_value[12] |-> !scl_oe_n)
    else $error("Clock line not held low");
  chk_release_free: assert property (
    ctl_value[15] && $past(module_run) && ctl_value[12] && !$past(eng_scl_low) |-> scl_oe_n)
    else $error("Clock line not released");
  chk_scl_sync: assert property ($past(rst_n, 3) |-> scl_sync == $past(scl_in, 3))
    else $error("Clock level not synchronised");
endmodule : i2ccr_top_monitor

bind i2ccr_top i2ccr_top_monitor u_mon (.core_clk, .rst_n, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .scl_in, .scl_oe_n, .sda_oe_n, .gpio_scl_oe_n, .gpio_sda_oe_n, .sys_idle,
  .slave_active, .slave_tx_start, .slave_rx_done, .eng_scl_low, .module_on, .module_run,
  .ctl_value, .scl_sync);

//--- sim/i2ccr_bus_peer.sv
// Remote master on the two-wire bus, clocking one frame per start request
`timescale 1ns/1ps
module i2ccr_bus_peer #(
  parameter int HALF_NS = 400
) (
  input  wire logic start,
  input  wire logic scl_wire,
  output logic      scl_low,
  output logic      sda_low,
  output logic      busy,
  output logic      stretched
);
  initial {scl_low, sda_low, busy, stretched} = 4'h0;
  // One frame: start, nine clocks, stop; clock stands still outside it
  always @(posedge start) begin : frame
    int n;
    #13;
    busy = 1'b1;
    sda_low = 1'b1;
    #(HALF_NS);
    for (int b = 0; b < 9; b++) begin
      scl_low = 1'b1;
      sda_low = (b < 8) && ($urandom_range(1) == 1);
      #(HALF_NS);
      scl_low = 1'b0;
      n = 0;
      // Wait while a slave stretches the clock
      while (scl_wire !== 1'b1 && n < 4000) begin
        stretched = 1'b1;
        #100;
        n++;
      end
      #(HALF_NS);
    end
    sda_low = 1'b1;
    #(HALF_NS);
    sda_low = 1'b0;
    busy = 1'b0;
  end
endmodule : i2ccr_bus_peer

//--- sim/tb_i2ccr_top.sv
// Self-checking bench for the control and clock release block
`timescale 1ns/1ps
module tb_i2ccr_top;
  import i2ccr_pkg::*;
  logic        core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s;
  logic [1:0]  htrans = 2'h0;
  logic        sys_idle = 1'b0, slave_active = 1'b0, slave_tx_start = 1'b0, slave_rx_done = 1'b0;
  logic        gpio_scl_out = 1'b1, gpio_scl_oe_n = 1'b1, gpio_sda_out = 1'b1, gpio_sda_oe_n = 1'b1;
  logic        eng_scl_low = 1'b0, eng_sda_low = 1'b0, rx_load = 1'b0, port1_rx_load = 1'b0;
  logic        p_go = 1'b0;
  logic [7:0]  rx_byte = 8'h0, port1_rx_byte = 8'h0, tx_byte;
  logic        hready, hreadyout, hresp, scl_in, sda_in, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic        module_on, module_run, scl_sync, p_scl, p_sda, p_busy, p_str, rdy_s;
  logic [15:0] ctl_value;
  logic [9:0]  own_address, address_mask;
  logic [11:0] baud_divider;
  logic [31:0] mdl [0:7];
  int          bad_count = 0, check_count = 0;
  always #50 core_clk = ~core_clk;
  // Single slave, open-drain wires with pull-ups
  assign hready = hreadyout;
  assign scl_in = !(p_scl || (!scl_oe_n && !scl_out));
  assign sda_in = !(p_sda || (!sda_oe_n && !sda_out));
  // Settled bus answer, seen before the next rising edge
  always @(negedge core_clk) {rdy_s, rd_s} <= {hreadyout, hrdata};
  i2ccr_top DUT (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hrdata, .hresp, .scl_in, .sda_in, .scl_out, .scl_oe_n, .sda_out,
    .sda_oe_n, .gpio_scl_out, .gpio_scl_oe_n, .gpio_sda_out, .gpio_sda_oe_n, .sys_idle,
    .eng_scl_low, .eng_sda_low, .slave_active, .slave_tx_start, .slave_rx_done,
    .seq_done(5'h0), .status_live(16'h0), .status_event(16'h0), .rx_load, .rx_byte,
    .port1_rx_load, .port1_rx_byte, .module_on, .module_run, .ctl_value, .own_address,
    .address_mask, .baud_divider, .tx_byte, .tx_write(), .scl_sync, .sda_sync(), .scl_rise(),
    .scl_fall());
  i2ccr_bus_peer PEER (.start(p_go), .scl_wire(scl_in), .scl_low(p_scl), .sda_low(p_sda),
    .busy(p_busy), .stretched(p_str));
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp32
  task automatic cmp_pin(input string nm, input logic e, input logic s);
    cmp32(nm, {31'h0, e}, {31'h0, s});
  endtask : cmp_pin
  // Waits for hready at a rising edge, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    if (n >= 20) cmp_pin("hready", 1'b1, 1'b0);
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : xfer
  function automatic logic [31:0] msk(input int i);
    case (i)
      0: return CON_MASK;
      2: return ADD_MASK;
      3: return MSK_MASK;
      4: return BRG_MASK;
      5: return TRN_MASK;
      default: return ZERO_32;
    endcase
  endfunction : msk
  // Bus write plus the model's view of it
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int i;
    logic [31:0] o, n;
    xfer(1'b1, a, d);
    i = a[7:4];
    if (a[15:8] != 8'h51 || i > 5 || i == 1) return;
    o = mdl[i];
    case (a[3:2])
      2'h0: n = d;
      2'h1: n = o & ~d;
      2'h2: n = o | d;
      default: n = o ^ d;
    endcase
    n = n & msk(i);
    if (i == 0 && !o[6] && o[12]) n[12] = 1'b1;
    mdl[i] = n;
  endtask : wr
  task automatic rd_chk(input logic [31:0] a);
    logic [31:0] e;
    xfer(1'b0, a, 32'h0);
    e = ZERO_32;
    if (a[15:0] == OFS_P1_RCV) e = mdl[7];
    if (a[3:0] == 4'h0 && a[15:8] == 8'h51 && a[7:4] < 7) e = mdl[a[7:4]];
    cmp32("read", e, rd_s);
    cmp_pin("hresp", 1'b0, hresp);
  endtask : rd_chk
  // Pin hand-over, run state and control copy after inputs settle
  task automatic pin_chk;
    logic on, run;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    on = mdl[0][15];
    run = on && !(mdl[0][13] && sys_idle);
    cmp_pin("module_run", run, module_run);
    cmp32("ctl_value", {16'h0, mdl[0][15:0]}, {16'h0, ctl_value});
    cmp_pin("scl_oe_n", on ? (!run || !(eng_scl_low || (slave_active && !mdl[0][12])))
      : gpio_scl_oe_n, scl_oe_n);
    cmp_pin("sda_oe_n", on ? (!run || !eng_sda_low) : gpio_sda_oe_n, sda_oe_n);
    if (!on) cmp32("pin_out", {30'h0, gpio_scl_out, gpio_sda_out}, {30'h0, scl_out, sda_out});
    @(posedge core_clk);
  endtask : pin_chk
  // Watchdog against a hung handshake
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
  // Main sequence
  initial begin
    int r;
    logic [31:0] a;
    void'($urandom(32'hc97077d1));
    foreach (mdl[i]) mdl[i] = ZERO_32;
    mdl[0] = CON_RESET;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) rd_chk(32'h5100 + 32'(16 * i));
    rd_chk(32'h5200);
    rd_chk(32'h5064);
    rd_chk(32'h5104);
    rd_chk(32'h5170);
    wr(32'h5164, 32'hffff_ffff);
    rx_byte <= 8'($urandom);
    port1_rx_byte <= 8'($urandom);
    {rx_load, port1_rx_load} <= 2'h3;
    @(posedge core_clk);
    {rx_load, port1_rx_load} <= 2'h0;
    {mdl[6], mdl[7]} = {24'h0, rx_byte, 24'h0, port1_rx_byte};
    rd_chk(32'h5160);
    rd_chk(32'h5060);
    for (int k = 0; k < 48; k++) begin
      r = 2 + $urandom_range(3);
      a = 32'h5100 + 32'(16 * r) + 32'(4 * $urandom_range(3));
      wr(a, $urandom);
      rd_chk(a & ~32'hc);
    end
    cmp32("copies", {mdl[2][9:0], mdl[3][9:0], mdl[4][11:0]},
      {own_address, address_mask, baud_divider});
    cmp32("tx_byte", mdl[5] & TRN_MASK, {24'h0, tx_byte});
    for (int k = 0; k < 12; k++) begin
      if (k == 6) wr(32'h5108, 32'h8000);
      {gpio_scl_out, gpio_scl_oe_n, gpio_sda_out, gpio_sda_oe_n, eng_scl_low, eng_sda_low}
        <= 6'($urandom);
      pin_chk();
    end
    for (int k = 0; k < 4; k++) begin
      wr(k[1] ? 32'h5108 : 32'h5104, 32'h2000);
      sys_idle <= k[0];
      eng_scl_low <= 1'b1;
      pin_chk();
    end
    {sys_idle, eng_scl_low, eng_sda_low, slave_active} <= 4'h1;
    slave_tx_start <= 1'b1;
    @(posedge core_clk);
    slave_tx_start <= 1'b0;
    mdl[0][12] = 1'b0;
    pin_chk();
    rd_chk(32'h5100);
    p_go <= 1'b1;
    repeat (40) @(posedge core_clk);
    cmp_pin("stretched", 1'b1, p_str);
    wr(32'h5108, 32'h1000);
    pin_chk();
    for (int n = 0; n < 400 && p_busy; n++) @(posedge core_clk);
    cmp_pin("peer_busy", 1'b0, p_busy);
    p_go <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      wr(k ? 32'h5108 : 32'h5104, 32'h0040);
      slave_rx_done <= 1'b1;
      @(posedge core_clk);
      slave_rx_done <= 1'b0;
      if (mdl[0][6]) mdl[0][12] = 1'b0;
      pin_chk();
      wr(32'h5108, 32'h1000);
      wr(32'h5104, 32'h1000);
      pin_chk();
      rd_chk(32'h5100);
      wr(32'h5108, 32'h1000);
    end
    final_report();
  end
endmodule : tb_i2ccr_top
